// ==== common/homing_pkg.sv ====
//Contract
// - phase one runs at run rate until the near-origin input is active.
// - phase two runs at slow seek rate until the origin input is active.
// - phase three runs at slow seek rate until the index pulse is active.
// - phase four moves the offset count of pulses at run rate, no sensor.
// - each phase setting is 0 skip, 1 positive or 2 negative, on its own.
// - the offset accepts 0 up to 2147483647 pulses.
// - each axis holds its own slow seek rate in pulses per second.
// - a per-axis option lets the limit switch act as the origin input.
// - a start command launches homing on every selected idle axis at once; a selected axis that is busy ignores it.
// - each axis reports whether homing has completed or is still in progress.
// - a sensor phase ends on its active input; the next enabled one follows.
// - the run rate register sets run rate, nonzero and at most the maximum.
package homing_pkg;

  localparam int CLK_PERIOD_NS = 8;
  localparam int CLK_HZ        = 1000000000 / CLK_PERIOD_NS;
  localparam int MAX_RATE_PPS  = 4000000;
  localparam int RATE_W        = 22;
  localparam int ACC_W         = 28;
  localparam int OFFSET_W      = 31;
  localparam int CFG_W         = 9;
  localparam int CFG_LIMIT_BIT = 8;

  localparam logic [7:0] AXIS_STRIDE    = 8'h20;
  localparam logic [7:0] OFF_RUN_RATE   = 8'h00;
  localparam logic [7:0] OFF_SLOW_RATE  = 8'h04;
  localparam logic [7:0] OFF_PHASE_CFG  = 8'h08;
  localparam logic [7:0] OFF_OFFSET     = 8'h0C;
  localparam logic [7:0] OFF_START      = 8'h80;
  localparam logic [7:0] OFF_STATUS     = 8'h84;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h88;
  localparam logic [7:0] OFF_IRQ_MASK   = 8'h8C;

  localparam logic [31:0] RATE_RST   = 32'h0000_0000;
  localparam logic [8:0]  CFG_RST    = 9'h000;
  localparam logic [30:0] OFFSET_RST = 31'h0000_0000;
  localparam logic [3:0]  MASK_RST   = 4'h0;

  localparam logic [1:0] SET_SKIP = 2'h0;
  localparam logic [1:0] SET_POS  = 2'h1;
  localparam logic [1:0] SET_NEG  = 2'h2;

  typedef enum logic [2:0] {
    PH_IDLE   = 3'b000,
    PH_NEAR   = 3'b001,
    PH_ORIGIN = 3'b010,
    PH_INDEX  = 3'b011,
    PH_OFFSET = 3'b100
  } phase_e;

  // zero or over-range rates would stall or overrun the pulse generator
  function automatic logic [RATE_W-1:0] clamp_rate(input logic [31:0] r);
    if (r == 32'h0000_0000)
      clamp_rate = RATE_W'(1);
    else if (r > 32'(MAX_RATE_PPS))
      clamp_rate = RATE_W'(MAX_RATE_PPS);
    else
      clamp_rate = r[RATE_W-1:0];
  endfunction : clamp_rate

  // first enabled phase at or after index from; idle when none left
  function automatic phase_e first_phase(input logic [7:0] cfg,
                                         input int         from);
    phase_e p;
    p = PH_IDLE;
    for (int i = 3; i >= 0; i--)
    begin
      if (i >= from && (cfg[2*i +: 2] == SET_POS || cfg[2*i +: 2] == SET_NEG))
        p = phase_e'(3'(i + 1));
    end
    first_phase = p;
  endfunction : first_phase

endpackage : homing_pkg

// ==== core/homing_axis.sv ====
module homing_axis
  import homing_pkg::*;
(
  // clock and reset
  input  wire logic                clk,
  input  wire logic                arst_n,
  input  wire logic                ce,
  // configuration
  input  wire logic                start,
  input  wire logic [RATE_W-1:0]   run_rate,
  input  wire logic [RATE_W-1:0]   slow_rate,
  input  wire logic [CFG_W-1:0]    cfg,
  input  wire logic [OFFSET_W-1:0] offset,
  // sensors
  input  wire logic                near_in,
  input  wire logic                origin_in,
  input  wire logic                index_in,
  input  wire logic                lim_pos,
  input  wire logic                lim_neg,
  // motor side and status
  output logic                     pulse,
  output logic                     dir,
  output logic                     busy,
  output logic                     done_evt
);

  typedef struct packed {
    phase_e              ph;
    logic [ACC_W-1:0]    acc;
    logic [OFFSET_W-1:0] remain;
    logic                dir;
    logic                pulse;
    logic                done_evt;
  } axis_s;

  axis_s            s_reg;
  axis_s            s_next;
  logic [RATE_W-1:0] rate;
  logic [ACC_W-1:0]  sum;
  logic              hit;
  logic              lim_origin;

  always_comb
  begin
    s_next          = s_reg;
    s_next.pulse    = 1'b0;
    s_next.done_evt = 1'b0;
    lim_origin      = s_reg.dir ? lim_pos : lim_neg;
    if (s_reg.ph == PH_NEAR || s_reg.ph == PH_OFFSET)
      rate = run_rate;
    else
      rate = slow_rate;
    sum = s_reg.acc + ACC_W'(rate);
    case (s_reg.ph)
      PH_NEAR:   hit = near_in;
      PH_ORIGIN: hit = cfg[CFG_LIMIT_BIT] ? lim_origin : origin_in;
      PH_INDEX:  hit = index_in;
      PH_OFFSET: hit = (s_reg.remain == '0);
      default:   hit = 1'b0;
    endcase
    case (s_reg.ph)
      PH_IDLE:
      begin
        if (start)
        begin
          s_next.ph       = first_phase(cfg[7:0], 0);
          s_next.acc      = '0;
          s_next.remain   = offset;
          s_next.done_evt = (first_phase(cfg[7:0], 0) == PH_IDLE);
        end
      end
      default:
      begin
        if (hit)
        begin
          s_next.ph       = first_phase(cfg[7:0], int'(s_reg.ph));
          s_next.acc      = '0;
          s_next.done_evt = (s_next.ph == PH_IDLE);
        end
        else if (sum >= ACC_W'(CLK_HZ))
        begin
          // phase accumulator: average rate exact, jitter one clock
          s_next.acc   = sum - ACC_W'(CLK_HZ);
          s_next.pulse = 1'b1;
          if (s_reg.ph == PH_OFFSET)
            s_next.remain = s_reg.remain - OFFSET_W'(1);
        end
        else
          s_next.acc = sum;
      end
    endcase
    if (s_next.ph != PH_IDLE)
      s_next.dir = (cfg[2*(int'(s_next.ph) - 1) +: 2] == SET_POS);
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      s_reg <= '{ph: PH_IDLE, dir: 1'b1, default: '0};
    else if (ce)
      s_reg <= s_next;
  end

  assign pulse    = s_reg.pulse;
  assign dir      = s_reg.dir;
  assign busy     = (s_reg.ph != PH_IDLE);
  assign done_evt = s_reg.done_evt;

endmodule : homing_axis

// ==== core/homing_top.sv ====
// Design decisions made here: the register addresses and the APB register port.
module homing_top
  import homing_pkg::*;
#(
  parameter int AXES = 4
)
(
  // clock, reset, enable
  input  wire logic            REF_CLK,
  input  wire logic            ARST_N,
  input  wire logic            CE,
  // apb slave
  input  wire logic            PSEL,
  input  wire logic            PENABLE,
  input  wire logic            PWRITE,
  input  wire logic [7:0]      PADDR,
  input  wire logic [31:0]     PWDATA,
  output logic      [31:0]     PRDATA,
  output logic                 PREADY,
  output logic                 PSLVERR,
  // axis sensors
  input  wire logic [AXES-1:0] NEAR_ORIGIN_INPUT,
  input  wire logic [AXES-1:0] ORIGIN_INPUT,
  input  wire logic [AXES-1:0] INDEX_PULSE_INPUT,
  input  wire logic [AXES-1:0] LIMIT_POS,
  input  wire logic [AXES-1:0] LIMIT_NEG,
  // motor drive
  output logic      [AXES-1:0] PULSE_OUT,
  output logic      [AXES-1:0] DIR_OUT,
  // interrupt
  output logic                 IRQ
);

  typedef struct packed {
    logic [AXES-1:0][31:0]       run_rate;
    logic [AXES-1:0][31:0]       slow_rate;
    logic [AXES-1:0][CFG_W-1:0]  cfg;
    logic [AXES-1:0][OFFSET_W-1:0] offset;
    logic [AXES-1:0]             start;
    logic [AXES-1:0]             irq_stat;
    logic [AXES-1:0]             irq_mask;
    logic [31:0]                 rdata;
    logic                        slverr;
    logic                        rvalid;
  } regs_s;

  regs_s           r_reg;
  regs_s           r_next;

  logic [AXES-1:0] busy;
  logic [AXES-1:0] done_evt;

  // address decode
  logic            axis_hit;
  logic [1:0]      axis_idx;
  logic [7:0]      axis_off;
  logic            glob_hit;
  logic            mapped;
  logic            wr_go;
  logic [31:0]     rd_val;
  logic [AXES-1:0] w1c;

  // one aligned word per register; axes sit in strides of 0x20
  always_comb
  begin
    axis_idx = PADDR[6:5];
    axis_off = {3'b000, PADDR[4:0]};
    axis_hit = 1'b0;
    glob_hit = 1'b0;
    if (PADDR[1:0] != 2'b00)
      axis_hit = 1'b0;
    else if (PADDR < 8'(AXES * int'(AXIS_STRIDE)))
    begin
      if (axis_off == OFF_RUN_RATE)
        axis_hit = 1'b1;
      else if (axis_off == OFF_SLOW_RATE)
        axis_hit = 1'b1;
      else if (axis_off == OFF_PHASE_CFG)
        axis_hit = 1'b1;
      else if (axis_off == OFF_OFFSET)
        axis_hit = 1'b1;
    end
    else if (PADDR == OFF_START)
      glob_hit = 1'b1;
    else if (PADDR == OFF_STATUS)
      glob_hit = 1'b1;
    else if (PADDR == OFF_IRQ_STATUS)
      glob_hit = 1'b1;
    else if (PADDR == OFF_IRQ_MASK)
      glob_hit = 1'b1;
    mapped = axis_hit || glob_hit;
  end

  // read multiplexer
  always_comb
  begin
    rd_val = 32'h0000_0000;
    if (axis_hit)
    begin
      if (axis_off == OFF_RUN_RATE)
        rd_val = r_reg.run_rate[axis_idx];
      else if (axis_off == OFF_SLOW_RATE)
        rd_val = r_reg.slow_rate[axis_idx];
      else if (axis_off == OFF_PHASE_CFG)
        rd_val = 32'(r_reg.cfg[axis_idx]);
      else if (axis_off == OFF_OFFSET)
        rd_val = 32'(r_reg.offset[axis_idx]);
    end
    else if (PADDR == OFF_STATUS)
      rd_val = 32'({~busy, busy});
    else if (PADDR == OFF_IRQ_STATUS)
      rd_val = 32'(r_reg.irq_stat);
    else if (PADDR == OFF_IRQ_MASK)
      rd_val = 32'(r_reg.irq_mask);
  end

  // data captured in the setup cycle, so the access cycle reads flops
  assign PREADY  = PENABLE && r_reg.rvalid && CE;
  assign PRDATA  = r_reg.rdata;
  assign PSLVERR = PENABLE && r_reg.rvalid && r_reg.slverr;
  assign wr_go   = PSEL && PENABLE && r_reg.rvalid && PWRITE && mapped;

  always_comb
  begin
    r_next        = r_reg;
    r_next.start  = '0;
    r_next.rvalid = PSEL && !(PENABLE && r_reg.rvalid);
    w1c           = '0;
    if (PSEL && !r_reg.rvalid)
    begin
      r_next.rdata  = PWRITE ? 32'h0000_0000 : rd_val;
      r_next.slverr = !mapped;
    end
    if (wr_go && axis_hit)
    begin
      if (axis_off == OFF_RUN_RATE)
        r_next.run_rate[axis_idx] = PWDATA;
      else if (axis_off == OFF_SLOW_RATE)
        r_next.slow_rate[axis_idx] = PWDATA;
      else if (axis_off == OFF_PHASE_CFG)
        r_next.cfg[axis_idx] = PWDATA[CFG_W-1:0];
      else if (axis_off == OFF_OFFSET)
        r_next.offset[axis_idx] = PWDATA[OFFSET_W-1:0];
    end
    else if (wr_go && PADDR == OFF_START)
      r_next.start = PWDATA[AXES-1:0] & ~busy;
    else if (wr_go && PADDR == OFF_IRQ_STATUS)
      w1c = PWDATA[AXES-1:0];
    else if (wr_go && PADDR == OFF_IRQ_MASK)
      r_next.irq_mask = PWDATA[AXES-1:0];
    // a completion in the clearing cycle stays set
    r_next.irq_stat = (r_reg.irq_stat & ~w1c) | done_evt;
  end

  always_ff @(posedge REF_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      r_reg           <= '0;
      r_reg.run_rate  <= {AXES{RATE_RST}};
      r_reg.slow_rate <= {AXES{RATE_RST}};
      r_reg.cfg       <= {AXES{CFG_RST}};
      r_reg.offset    <= {AXES{OFFSET_RST}};
      r_reg.irq_mask  <= MASK_RST[AXES-1:0];
    end
    else if (CE)
      r_reg <= r_next;
  end

  assign IRQ = |(r_reg.irq_stat & r_reg.irq_mask);

  // all selected axes run side by side
  for (genvar a = 0; a < AXES; a++)
  begin : g_axis
    homing_axis u_axis (
      .clk       (REF_CLK),
      .arst_n    (ARST_N),
      .ce        (CE),
      .start     (r_reg.start[a]),
      .run_rate  (clamp_rate(r_reg.run_rate[a])),
      .slow_rate (clamp_rate(r_reg.slow_rate[a])),
      .cfg       (r_reg.cfg[a]),
      .offset    (r_reg.offset[a]),
      .near_in   (NEAR_ORIGIN_INPUT[a]),
      .origin_in (ORIGIN_INPUT[a]),
      .index_in  (INDEX_PULSE_INPUT[a]),
      .lim_pos   (LIMIT_POS[a]),
      .lim_neg   (LIMIT_NEG[a]),
      .pulse     (PULSE_OUT[a]),
      .dir       (DIR_OUT[a]),
      .busy      (busy[a]),
      .done_evt  (done_evt[a])
    );
  end

endmodule : homing_top

// ==== dv/axis_sensor_model.sv ====
module axis_sensor_model
#(
  parameter int NEAR_AT = -3
)
(
  // clock and motor drive
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic [3:0] pulse,
  input  wire logic [3:0] dir,
  // sensors
  output logic      [3:0] near,
  output logic      [3:0] origin,
  output logic      [3:0] index,
  output logic      [3:0] lim_pos,
  output logic      [3:0] lim_neg,
  output int              pos [4]
);
  timeunit 1ns;
  timeprecision 1ps;
  always_ff @(posedge clk or negedge arst_n)
  begin
    for (int a = 0; a < 4; a++)
      if (!arst_n)
        pos[a] <= 0;
      else if (pulse[a])
        pos[a] <= pos[a] + (dir[a] ? 1 : -1);
  end
  // index repeats every four pulses, so a late index search still ends
  always_comb
  begin
    for (int a = 0; a < 4; a++)
    begin
      near[a]    = pos[a] <= NEAR_AT;
      origin[a]  = pos[a] <= NEAR_AT - 2;
      index[a]   = pos[a][1:0] == 2'h0 && pos[a] != 0;
      lim_neg[a] = pos[a] <= -9;
      lim_pos[a] = pos[a] >= 9;
    end
  end
endmodule : axis_sensor_model

// ==== dv/homing_chk.sv ====
module homing_chk
  import homing_pkg::*;
#(
  parameter int AXES = 4
)
(
  // clock and apb
  input wire logic            REF_CLK,
  input wire logic            ARST_N,
  input wire logic            PSEL,
  input wire logic            PENABLE,
  input wire logic            PWRITE,
  input wire logic [7:0]      PADDR,
  input wire logic [31:0]     PWDATA,
  input wire logic [31:0]     PRDATA,
  input wire logic            PREADY,
  input wire logic            PSLVERR,
  // axis side
  input wire logic [AXES-1:0] PULSE_OUT,
  input wire logic [AXES-1:0] DIR_OUT,
  input wire logic            IRQ
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!ARST_N);
  logic       xfer;
  logic       rd;
  logic       go0;
  logic [8:0] cfg0_reg;
  logic       run0_reg;
  assign xfer = PSEL & PENABLE & PREADY;
  assign rd   = xfer & !PWRITE;
  assign go0  = xfer & PWRITE & (PADDR == OFF_START) & PWDATA[0];
  // shadow of axis 0 settings; host leaves them alone while homing
  always_ff @(posedge REF_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      cfg0_reg <= CFG_RST;
      run0_reg <= 1'b0;
    end
    else
    begin
      if (xfer & PWRITE & (PADDR == OFF_PHASE_CFG))
        cfg0_reg <= PWDATA[8:0];
      if (go0)
        run0_reg <= 1'b1;
    end
  end
  sequence s_go_dir;
    go0 && (cfg0_reg[1:0] == SET_POS || cfg0_reg[1:0] == SET_NEG);
  endsequence
  property p_gap;
    (PULSE_OUT & $past(PULSE_OUT)) == '0;
  endproperty
  a_gap: assert property (p_gap) else $error("pulses back to back");
  // cycles since the last pulse; the maximum rate keeps pulses 31 apart
  logic [5:0] gap_reg [AXES];
  logic       fast;
  always_ff @(posedge REF_CLK or negedge ARST_N)
  begin
    for (int a = 0; a < AXES; a++)
      if (!ARST_N)
        gap_reg[a] <= 6'h3F;
      else if (PULSE_OUT[a])
        gap_reg[a] <= 6'h00;
      else if (gap_reg[a] != 6'h3F)
        gap_reg[a] <= gap_reg[a] + 6'h01;
  end
  always_comb
  begin
    fast = 1'b0;
    for (int a = 0; a < AXES; a++)
      if (PULSE_OUT[a] && gap_reg[a] < 6'h1E)
        fast = 1'b1;
  end
  property p_rate;
    !fast;
  endproperty
  a_rate: assert property (p_rate) else $error("rate over maximum");
  property p_idle;
    !run0_reg |-> !PULSE_OUT[0];
  endproperty
  a_idle: assert property (p_idle) else $error("pulse before start");
  property p_skip;
    go0 && cfg0_reg[7:0] == 8'h00 |=> !PULSE_OUT[0] [*8];
  endproperty
  a_skip: assert property (p_skip) else $error("skip moved");
  property p_dir;
    s_go_dir |-> ##3 DIR_OUT[0] == (cfg0_reg[1:0] == SET_POS);
  endproperty
  a_dir: assert property (p_dir) else $error("wrong direction");
  property p_stat;
    rd && PADDR == OFF_STATUS |-> PRDATA[7:4] == ~PRDATA[3:0];
  endproperty
  a_stat: assert property (p_stat) else $error("status mismatch");
  property p_mask;
    xfer && PWRITE && PADDR == OFF_IRQ_MASK && PWDATA[3:0] == 4'h0
      |=> !IRQ;
  endproperty
  a_mask: assert property (p_mask) else $error("irq not masked");
  property p_start_rd;
    rd && PADDR == OFF_START |-> PRDATA == '0 && !PSLVERR;
  endproperty
  a_start_rd: assert property (p_start_rd) else $error("start read");
  property p_err;
    xfer && PADDR[1:0] != 2'h0 |-> PSLVERR && PRDATA == '0;
  endproperty
  a_err: assert property (p_err) else $error("misaligned taken");
endmodule : homing_chk

bind homing_top homing_chk #(.AXES(AXES)) u_chk (
  .REF_CLK(REF_CLK), .ARST_N(ARST_N), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
  .PREADY(PREADY), .PSLVERR(PSLVERR), .PULSE_OUT(PULSE_OUT),
  .DIR_OUT(DIR_OUT), .IRQ(IRQ)
);

// ==== dv/homing_top_tb.sv ====
module homing_top_tb
  import homing_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, arst_n, psel, penable, pwrite, pready, pslverr, irq;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  near, origin, index, lim_p, lim_n, pulse, dir;
  logic        err;
  int          pos [4];
  int          error_cnt;
  int          checked;
  int          cyc;
  homing_top dut (
    .REF_CLK(clk), .ARST_N(arst_n), .CE(1'b1), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .NEAR_ORIGIN_INPUT(near), .ORIGIN_INPUT(origin),
    .INDEX_PULSE_INPUT(index), .LIMIT_POS(lim_p), .LIMIT_NEG(lim_n),
    .PULSE_OUT(pulse), .DIR_OUT(dir), .IRQ(irq));
  axis_sensor_model u_model (
    .clk(clk), .arst_n(arst_n), .pulse(pulse), .dir(dir), .near(near),
    .origin(origin), .index(index), .lim_pos(lim_p), .lim_neg(lim_n),
    .pos(pos));
  task automatic test_done;
    $display("checked %0d error_cnt %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : test_done
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
                     input string what);
    checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
      @(posedge clk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e,
                       input string what);
    apb(1'b0, a, 32'h0);
    chk(rd, e, what);
  endtask : rdchk
  task automatic setup(input logic [7:0] b, input logic [31:0] c,
                       input logic [31:0] off);
    apb(1'b1, b + OFF_RUN_RATE, 32'h003D_0900);
    apb(1'b1, b + OFF_SLOW_RATE, 32'h000F_4240);
    apb(1'b1, b + OFF_PHASE_CFG, c);
    apb(1'b1, b + OFF_OFFSET, off);
  endtask : setup
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      error_cnt++;
      test_done();
    end
  end
  initial
  begin
    arst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    rdchk(OFF_RUN_RATE, RATE_RST, "run rate");
    rdchk(OFF_PHASE_CFG, 32'(CFG_RST), "settings");
    rdchk(OFF_STATUS, 32'h0000_00F0, "idle status");
    rdchk(OFF_START, 32'h0, "start");
    rdchk(8'h85, 32'h0, "misaligned");
    chk(32'(err), 32'h1, "slave error");
    apb(1'b1, AXIS_STRIDE + OFF_OFFSET, 32'h7FFF_FFFF);
    rdchk(AXIS_STRIDE + OFF_OFFSET, 32'h7FFF_FFFF, "offset");
    // all phases skipped: completes at once, no motion
    apb(1'b1, OFF_IRQ_MASK, 32'hF);
    apb(1'b1, OFF_START, 32'h1);
    // status bit lands two edges after the start write
    repeat (2) @(posedge clk);
    rdchk(OFF_IRQ_STATUS, 32'h1, "skip irq");
    chk(32'(irq), 32'h1, "irq line");
    chk(32'(pos[0]), 32'h0, "skip motion");
    apb(1'b1, OFF_IRQ_STATUS, 32'h1);
    // axis 0 neg,neg,pos,pos; axis 1 limit as origin; axis 2 offset only
    setup(8'h00, 32'h0000_005A, 32'h3);
    setup(8'h20, 32'h0000_0108, 32'h0);
    setup(8'h40, 32'h0000_0080, 32'h5);
    // axis 2 run rate over range, so it must run clamped
    apb(1'b1, 8'h40 + OFF_RUN_RATE, 32'hFFFF_FFFF);
    apb(1'b1, OFF_START, 32'h7);
    // axis 1 has four slow pulses by now; run rate would reach the limit
    repeat (600) @(posedge clk);
    chk(32'(pos[1]), 32'hFFFF_FFFC, "slow seek");
    rd = 32'hF;
    while ((rd[3:0] & 4'h7) !== 4'h0)
      apb(1'b0, OFF_STATUS, 32'h0);
    rdchk(OFF_STATUS, 32'h0000_00F0, "done status");
    chk(32'(pos[0]), 32'hFFFF_FFFF, "axis 0 home");
    chk(32'(pos[1]), 32'hFFFF_FFF7, "axis 1 limit");
    chk(32'(pos[2]), 32'hFFFF_FFFB, "axis 2 home");
    rdchk(OFF_IRQ_STATUS, 32'h7, "done irq");
    apb(1'b1, OFF_IRQ_MASK, 32'h0);
    @(posedge clk);
    chk(32'(irq), 32'h0, "masked irq");
    apb(1'b1, OFF_IRQ_STATUS, 32'h7);
    rdchk(OFF_IRQ_STATUS, 32'h0, "cleared irq");
    test_done();
  end
endmodule : homing_top_tb
